// ==== hw/flash_lock_host.sv ====
// host sequencer for lock-bit, erase and status commands of a byte-wide flash
`timescale 1ns/1ps
`default_nettype none
// How it works
// - lock set is setup write then confirm; block confirm addresses target block
// - setup 60H, block confirm 01H, master confirm F1H
// - clear all locks is 60H then D0H at any address
// - host polls ready pin and status bit 7 before reading result
// - interrupted clear leaves locks undefined; host must repeat the clear, but it only raises RETRY_CLEAR
// - status bits 6..0 ignored while busy
// - host masks reserved status bit 0 on every poll
// - erase is 20H then D0H in block, then poll ready
// - host writes FFH after last erase to return to array read; it does so only for an OP_READ_ARRAY op
module flash_lock_host
  import flash_lock_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  input  wire logic              CLK,
  input  wire logic              RESETN,
  // user command port
  input  wire logic              OP_VALID,
  input  wire op_t               OP_CODE,
  input  wire logic [ADDR_W-1:0] OP_ADDR,
  input  wire logic              HIGH_VOLT_RESET,
  output logic                   OP_READY,
  output logic                   OP_DONE,
  output logic [7:0]             OP_STATUS,
  output logic                   ERR_SEQUENCE,
  output logic                   ERR_PROTECT,
  output logic                   ERR_SUPPLY,
  output logic                   ERR_OPERATION,
  output logic                   RETRY_CLEAR,
  // flash pins
  output logic [ADDR_W-1:0]      FLASH_ADDR,
  output logic                   FLASH_CE_N,
  output logic                   FLASH_WE_N,
  output logic                   FLASH_OE_N,
  output logic                   FLASH_RESET_HV,
  output logic                   FLASH_RESET_N,
  output logic [7:0]             FLASH_DQ_OUT,
  output logic                   FLASH_DQ_OE,
  input  wire logic [7:0]        FLASH_DQ_IN,
  input  wire logic              FLASH_READY_BUSY
);
  bus_cycle_if cyc ();

  logic [7:0] dq_s1_q, dq_s2_q;
  logic       rb_s1_q, rb_s2_q;
  state_t     st_q, st_d;
  op_t        op_q, op_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic       hv_q, hv_d;
  logic [7:0] stat_q, stat_d;
  logic       done_q, done_d;
  logic       req_q, req_d;
  logic       wr_q, wr_d;
  logic [7:0] wd_q, wd_d;
  logic       retry_q, retry_d;
  logic [7:0] masked;

  // pin inputs cross two flops before any use
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
      rb_s1_q <= 1'b0;
      rb_s2_q <= 1'b0;
    end else begin
      dq_s1_q <= FLASH_DQ_IN;
      dq_s2_q <= dq_s1_q;
      rb_s1_q <= FLASH_READY_BUSY;
      rb_s2_q <= rb_s1_q;
    end
  end

  bus_cycle_engine u_eng (
    .clk     (CLK),
    .resetn  (RESETN),
    .cyc     (cyc),
    .ce_n    (FLASH_CE_N),
    .we_n    (FLASH_WE_N),
    .oe_n    (FLASH_OE_N),
    .dq_out  (FLASH_DQ_OUT),
    .dq_oe   (FLASH_DQ_OE),
    .dq_sync (dq_s2_q)
  );

  assign masked = cyc.rdata & SR_VALID_MASK;

  // first and second command byte per operation
  function automatic logic [7:0] first_byte(input op_t op);
    case (op)
      OP_SET_BLOCK, OP_SET_MASTER, OP_CLEAR_ALL: first_byte = CMD_LOCK_SETUP;
      OP_ERASE:      first_byte = CMD_ERASE_SETUP;
      OP_CLR_STATUS: first_byte = CMD_CLEAR_STATUS;
      default:       first_byte = CMD_READ_ARRAY;
    endcase
  endfunction

  function automatic logic [7:0] second_byte(input op_t op);
    case (op)
      OP_SET_BLOCK:  second_byte = CMD_BLOCK_CONFIRM;
      OP_SET_MASTER: second_byte = CMD_MASTER_CONFIRM;
      OP_CLEAR_ALL:  second_byte = CMD_CLEAR_CONFIRM;
      default:       second_byte = CMD_ERASE_CONFIRM;
    endcase
  endfunction

  function automatic logic two_cycle(input op_t op);
    two_cycle = (op == OP_SET_BLOCK) || (op == OP_SET_MASTER) ||
                (op == OP_CLEAR_ALL) || (op == OP_ERASE);
  endfunction

  // sequencer: setup write, confirm write, status poll
  always_comb begin
    st_d    = st_q;
    op_d    = op_q;
    addr_d  = addr_q;
    hv_d    = hv_q;
    stat_d  = stat_q;
    done_d  = 1'b0;
    req_d   = 1'b0;
    wr_d    = wr_q;
    wd_d    = wd_q;
    retry_d = retry_q;
    case (st_q)
      ST_IDLE: begin
        if (OP_VALID) begin
          op_d   = OP_CODE;
          addr_d = OP_ADDR; // block address kept for both writes
          hv_d   = HIGH_VOLT_RESET; // override level held for the sequence
          req_d  = 1'b1;
          wr_d   = 1'b1;
          wd_d   = first_byte(OP_CODE);
          st_d   = ST_CMD1;
        end
      end
      ST_CMD1: begin
        if (cyc.done) begin
          if (two_cycle(op_q)) begin
            req_d = 1'b1;
            wd_d  = second_byte(op_q);
            st_d  = ST_CMD2;
          end else begin
            st_d  = ST_DONE;
          end
        end
      end
      ST_CMD2: begin
        if (cyc.done) begin
          req_d = 1'b1; // device now returns status on reads
          wr_d  = 1'b0;
          st_d  = ST_POLL;
        end
      end
      ST_POLL: begin
        if (cyc.done) begin
          if (rb_s2_q && cyc.rdata[SR_READY]) begin
            stat_d = masked;
            if (op_q == OP_CLEAR_ALL)
              retry_d = masked[SR_ERASE_ERR] & ~masked[SR_WRITE_ERR];
            st_d = ST_DONE;
          end else begin
            req_d = 1'b1; // busy: read again, other bits ignored
          end
        end
      end
      ST_DONE: begin
        done_d = 1'b1;
        st_d   = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      st_q    <= ST_IDLE;
      op_q    <= OP_READ_ARRAY;
      addr_q  <= '0;
      hv_q    <= 1'b0;
      stat_q  <= STATUS_RESET;
      done_q  <= 1'b0;
      req_q   <= 1'b0;
      wr_q    <= 1'b0;
      wd_q    <= 8'h00;
      retry_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      op_q    <= op_d;
      addr_q  <= addr_d;
      hv_q    <= hv_d;
      stat_q  <= stat_d;
      done_q  <= done_d;
      req_q   <= req_d;
      wr_q    <= wr_d;
      wd_q    <= wd_d;
      retry_q <= retry_d;
    end
  end

  assign cyc.req   = req_q;
  assign cyc.write = wr_q;
  assign cyc.wdata = wd_q;

  assign OP_READY       = (st_q == ST_IDLE);
  assign OP_DONE        = done_q;
  assign OP_STATUS      = stat_q;
  // decode kept bits; sticky in the device until clear-status
  assign ERR_SEQUENCE   = stat_q[SR_ERASE_ERR] & stat_q[SR_WRITE_ERR];
  assign ERR_PROTECT    = stat_q[SR_PROTECT];
  assign ERR_SUPPLY     = stat_q[SR_SUPPLY];
  assign ERR_OPERATION  = stat_q[SR_ERASE_ERR] ^ stat_q[SR_WRITE_ERR];
  assign RETRY_CLEAR    = retry_q;
  assign FLASH_ADDR     = addr_q;
  assign FLASH_RESET_HV = hv_q & (st_q != ST_IDLE); // high voltage only during a sequence
  assign FLASH_RESET_N  = RESETN;
endmodule
`default_nettype wire

// ==== hw/flash_lock_pkg.sv ====
// constants and types shared by the flash lock-bit host controller
package flash_lock_pkg;
  // command codes placed on the data bus
  localparam logic [7:0] CMD_LOCK_SETUP    = 8'h60;
  localparam logic [7:0] CMD_BLOCK_CONFIRM = 8'h01;
  localparam logic [7:0] CMD_MASTER_CONFIRM = 8'hF1;
  localparam logic [7:0] CMD_CLEAR_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_ERASE_SETUP   = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_READ_ARRAY    = 8'hFF;
  localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;
  localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
  // status word bit positions
  localparam int SR_READY     = 7;
  localparam int SR_ERASE_SUS = 6;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_WRITE_ERR = 4;
  localparam int SR_SUPPLY    = 3;
  localparam int SR_WR_SUS    = 2;
  localparam int SR_PROTECT   = 1;
  localparam logic [7:0] SR_VALID_MASK = 8'hFE;
  // bus cycle timing at 40 MHz
  localparam int CLK_PERIOD_NS = 25;
  localparam int WE_PULSE_NS   = 50;
  localparam int RD_ACCESS_NS  = 100;
  localparam int WE_CYCLES = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_CYCLES = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] WE_COUNT = 4'(WE_CYCLES);
  localparam logic [3:0] RD_COUNT = 4'(RD_CYCLES);
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // user operations
  typedef enum logic [2:0] {
    OP_SET_BLOCK  = 3'h0,
    OP_SET_MASTER = 3'h1,
    OP_CLEAR_ALL  = 3'h2,
    OP_ERASE      = 3'h3,
    OP_CLR_STATUS = 3'h4,
    OP_READ_ARRAY = 3'h5
  } op_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CMD1  = 3'b001,
    ST_CMD2  = 3'b011,
    ST_POLL  = 3'b010,
    ST_DONE  = 3'b110
  } state_t;
endpackage

// ==== hw/bus_cycle_if.sv ====
// handshake between the sequencer and the bus cycle engine
`timescale 1ns/1ps
`default_nettype none
interface bus_cycle_if;
  logic       req;
  logic       write;
  logic [7:0] wdata;
  logic       done;
  logic [7:0] rdata;
  modport seq (output req, output write, output wdata, input done, input rdata);
  modport eng (input req, input write, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// ==== hw/bus_cycle_engine.sv ====
// one write or read cycle on the flash parallel bus
`timescale 1ns/1ps
`default_nettype none
module bus_cycle_engine
  import flash_lock_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  bus_cycle_if.eng        cyc,
  output logic            ce_n,
  output logic            we_n,
  output logic            oe_n,
  output logic [7:0]      dq_out,
  output logic            dq_oe,
  input  wire logic [7:0] dq_sync
);
  logic [3:0] cnt_q, cnt_d;
  logic       busy_q, busy_d;
  logic       wr_q, wr_d;
  logic [7:0] dout_q, dout_d;
  logic [7:0] rd_q, rd_d;
  logic       done_q, done_d;

  // strobe held for a counted time, data latched at its end
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    wr_d   = wr_q;
    dout_d = dout_q;
    rd_d   = rd_q;
    done_d = 1'b0;
    if (!busy_q) begin
      if (cyc.req) begin
        busy_d = 1'b1;
        wr_d   = cyc.write;
        dout_d = cyc.wdata;
        cnt_d  = cyc.write ? WE_COUNT : RD_COUNT;
      end
    end else if (cnt_q != 4'h0) begin
      cnt_d = cnt_q - 4'h1;
    end else begin
      busy_d = 1'b0;
      done_d = 1'b1;
      if (!wr_q) rd_d = dq_sync; // sampled before strobe rises
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_q  <= 4'h0;
      busy_q <= 1'b0;
      wr_q   <= 1'b0;
      dout_q <= 8'h00;
      rd_q   <= 8'h00;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      wr_q   <= wr_d;
      dout_q <= dout_d;
      rd_q   <= rd_d;
      done_q <= done_d;
    end
  end

  assign ce_n      = ~busy_q;
  assign we_n      = ~(busy_q & wr_q & (cnt_q != 4'h0)); // rising edge latches data
  assign oe_n      = ~(busy_q & ~wr_q);
  assign dq_oe     = busy_q & wr_q;
  assign dq_out    = dout_q;
  assign cyc.done  = done_q;
  assign cyc.rdata = rd_q;
endmodule
`default_nettype wire

// ==== verif/flash_lock_host_asserts.sv ====
// port checks for the lock-bit host controller
`timescale 1ns/1ps
`default_nettype none
module flash_lock_host_chk
  import flash_lock_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RESETN,
  input wire logic       OP_VALID,
  input wire logic       OP_READY,
  input wire logic       OP_DONE,
  input wire logic [7:0] OP_STATUS,
  input wire logic       ERR_SEQUENCE,
  input wire logic       FLASH_CE_N,
  input wire logic       FLASH_WE_N,
  input wire logic       FLASH_OE_N,
  input wire logic       FLASH_DQ_OE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // a polled result never carries the reserved bit
  a_mask_reserved: assert property (OP_DONE |-> !OP_STATUS[0])
    else $error("reserved bit seen");
  a_done_ready: assert property (OP_DONE |-> OP_STATUS[SR_READY])
    else $error("done while busy");
  a_done_single: assert property (OP_DONE |=> !OP_DONE)
    else $error("done too long");
  // every op begins with a write strobe soon after it is taken
  a_op_starts: assert property (OP_VALID && OP_READY |-> ##[1:3] !FLASH_WE_N)
    else $error("no setup write");
  a_write_frame: assert property (!FLASH_WE_N |-> !FLASH_CE_N && FLASH_DQ_OE)
    else $error("bad write frame");
  a_write_width: assert property ($fell(FLASH_WE_N) |=> !FLASH_WE_N ##1 FLASH_WE_N)
    else $error("write pulse width");
  // host lets go of the data bus before the device drives it
  a_read_release: assert property (!FLASH_OE_N |-> !FLASH_DQ_OE && !FLASH_CE_N)
    else $error("bus contention");
  a_seq_flag: assert property (ERR_SEQUENCE == (OP_STATUS[5] && OP_STATUS[4]))
    else $error("sequence flag wrong");
endmodule
bind flash_lock_host flash_lock_host_chk u_chk (
  .CLK, .RESETN, .OP_VALID, .OP_READY, .OP_DONE, .OP_STATUS, .ERR_SEQUENCE,
  .FLASH_CE_N, .FLASH_WE_N, .FLASH_OE_N, .FLASH_DQ_OE
);
`default_nettype wire

// ==== verif/flash_dev_model.sv ====
// behavioural flash device: command decode, lock bits, status word
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
  import flash_lock_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [19:0] addr,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        hv,
  input  wire logic [7:0]  dq_w,
  input  wire logic        vpp_ok,
  input  wire logic        bad_seq,
  input  wire logic        slow,
  output logic [7:0]       dq_r,
  output logic             rdy
);
  // lock bits ignore reset: only clk drives them
  logic [15:0] lock_q = '0;
  logic        master_q = 1'b0;
  logic [7:0]  err_q = 8'h00;
  logic [7:0]  setup_q = 8'h00;
  logic        arr_q = 1'b0;
  logic [6:0]  busy_q = 7'h00;
  logic        we_q = 1'b1;
  logic [7:0]  last_q = 8'h00;
  logic [3:0]  blk;
  logic [7:0]  cmd;
  logic [7:0]  drv;
  assign blk = addr[19:16];
  // a garbled confirm stands for a broken sequence from the host
  assign cmd = (bad_seq && setup_q != 8'h00) ? 8'h3C : dq_w;
  // busy noise hides bits 6..0; reserved bit 0 is set to catch masking slips
  assign drv = arr_q ? 8'hFF : (busy_q != 0) ? {1'b0, ~err_q[6:0]} : {1'b1, err_q[6:1], 1'b1};
  assign dq_r = (!ce_n && !oe_n) ? drv : ~last_q;
  assign rdy = (busy_q == 0);
  // a byte is taken as write enable rises inside chip enable
  always @(posedge clk) begin
    we_q <= we_n;
    if (!ce_n && !oe_n) last_q <= drv;
    if (busy_q != 0) busy_q <= busy_q - 7'h01;
    if (!ce_n && we_n && !we_q) begin
      arr_q <= 1'b0;
      setup_q <= 8'h00;
      if (setup_q == CMD_LOCK_SETUP) begin
        busy_q <= slow ? 7'h28 : 7'h03;
        if (cmd == CMD_BLOCK_CONFIRM) begin
          if (master_q && !hv) err_q <= err_q | 8'h12;
          else lock_q[blk] <= 1'b1;
        end else if (cmd == CMD_MASTER_CONFIRM) begin
          if (!hv) err_q <= err_q | 8'h12;
          else master_q <= 1'b1;
        end else if (cmd == CMD_CLEAR_CONFIRM) begin
          if (!vpp_ok) err_q <= err_q | 8'h28;
          else if (master_q && !hv) err_q <= err_q | 8'h22;
          else lock_q <= '0;
        end else err_q <= err_q | 8'h30;
      end else if (setup_q == CMD_ERASE_SETUP) begin
        busy_q <= slow ? 7'h28 : 7'h03;
        if (cmd != CMD_ERASE_CONFIRM) err_q <= err_q | 8'h30;
        else if (!vpp_ok) err_q <= err_q | 8'h28;
        else if (lock_q[blk] && !hv) err_q <= err_q | 8'h22;
      end else if (cmd == CMD_CLEAR_STATUS) err_q <= 8'h00;
      else if (cmd == CMD_READ_ARRAY) arr_q <= 1'b1;
      else setup_q <= cmd;
    end
  end
endmodule
`default_nettype wire

// ==== verif/flash_lock_host_bench.sv ====
// self-checking bench: lock, erase and status sequences against the model
`timescale 1ns/1ps
`default_nettype none
module flash_lock_host_bench
  import flash_lock_pkg::*;
;
  logic        clk, rst_n, op_valid, hv_req, vpp_ok, bad_seq, slow;
  op_t         op_code;
  logic [19:0] op_addr, f_addr;
  logic [7:0]  op_status, f_dq_o, f_dq_i, dq_bus;
  wire         op_ready, op_done, err_seq, err_prot, err_sup, err_op, retry;
  wire         f_ce, f_we, f_oe, f_hv, f_dq_oe, f_rdy, f_rn;
  int          err_total, check_count, cycles;
  // the wire carries the host byte only while the host enables it
  assign dq_bus = f_dq_oe ? f_dq_o : f_dq_i;
  flash_lock_host DUT (.CLK(clk), .RESETN(rst_n), .OP_VALID(op_valid), .OP_CODE(op_code),
    .OP_ADDR(op_addr), .HIGH_VOLT_RESET(hv_req), .OP_READY(op_ready), .OP_DONE(op_done),
    .OP_STATUS(op_status), .ERR_SEQUENCE(err_seq), .ERR_PROTECT(err_prot),
    .ERR_SUPPLY(err_sup), .ERR_OPERATION(err_op), .RETRY_CLEAR(retry), .FLASH_ADDR(f_addr),
    .FLASH_CE_N(f_ce), .FLASH_WE_N(f_we), .FLASH_OE_N(f_oe), .FLASH_RESET_HV(f_hv),
    .FLASH_RESET_N(f_rn), .FLASH_DQ_OUT(f_dq_o), .FLASH_DQ_OE(f_dq_oe), .FLASH_DQ_IN(f_dq_i),
    .FLASH_READY_BUSY(f_rdy));
  flash_dev_model u_dev (.clk(clk), .addr(f_addr), .ce_n(f_ce), .we_n(f_we), .oe_n(f_oe),
    .hv(f_hv), .dq_w(dq_bus), .vpp_ok(vpp_ok), .bad_seq(bad_seq), .slow(slow),
    .dq_r(f_dq_i), .rdy(f_rdy));
  always #12.5 clk = ~clk;
  task automatic give_verdict;
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one user op, waited for under a bound, then result and flags compared
  task automatic run(input op_t op, input logic [3:0] b, input logic hv, input logic vp,
                     input logic bad, input logic [7:0] e);
    int n;
    n = 0;
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= op;
    op_addr <= {b, 16'h0123};
    hv_req <= hv;
    vpp_ok <= vp;
    bad_seq <= bad;
    slow <= ~slow;
    @(posedge clk);
    op_valid <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (op_done !== 1'b1 && n < 400);
    check({7'h00, n < 400}, 8'h01);
    // back in idle and the device kept out of reset once the op is reported
    check({6'h00, op_ready, f_rn}, 8'h03);
    check(op_status, e);
    check({4'h0, err_seq, err_prot, err_sup, err_op}, {4'h0, e[5] & e[4], e[1], e[3], e[5] ^ e[4]});
    if (op == OP_CLEAR_ALL) check({7'h00, retry}, {7'h00, e[5] & ~e[4]});
  endtask
  task automatic clr(input logic [7:0] e);
    run(OP_CLR_STATUS, 4'h0, 1'b0, 1'b1, 1'b0, e);
  endtask
  // hang guard sized well above the longest expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    clk = 0; rst_n = 0; op_valid = 0; op_code = OP_ERASE; op_addr = 20'h00000;
    hv_req = 0; vpp_ok = 1; bad_seq = 0; slow = 0; err_total = 0; check_count = 0; cycles = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    run(OP_ERASE, 4'h1, 1'b0, 1'b1, 1'b0, 8'h80);
    run(OP_SET_BLOCK, 4'h1, 1'b0, 1'b1, 1'b0, 8'h80);
    run(OP_ERASE, 4'h1, 1'b0, 1'b1, 1'b0, 8'hA2);
    run(OP_SET_BLOCK, 4'h2, 1'b0, 1'b1, 1'b0, 8'hA2);
    clr(8'hA2);
    run(OP_ERASE, 4'h1, 1'b1, 1'b1, 1'b0, 8'h80);
    run(OP_SET_MASTER, 4'h0, 1'b0, 1'b1, 1'b0, 8'h92);
    clr(8'h92);
    run(OP_SET_MASTER, 4'h5, 1'b1, 1'b1, 1'b0, 8'h80);
    run(OP_SET_BLOCK, 4'h3, 1'b0, 1'b1, 1'b0, 8'h92);
    clr(8'h92);
    run(OP_SET_BLOCK, 4'h3, 1'b1, 1'b1, 1'b0, 8'h80);
    run(OP_CLEAR_ALL, 4'h0, 1'b0, 1'b1, 1'b0, 8'hA2);
    clr(8'hA2);
    run(OP_CLEAR_ALL, 4'h0, 1'b1, 1'b0, 1'b0, 8'hA8);
    clr(8'hA8);
    run(OP_ERASE, 4'h2, 1'b0, 1'b1, 1'b0, 8'hA2);
    clr(8'hA2);
    run(OP_CLEAR_ALL, 4'h7, 1'b1, 1'b1, 1'b0, 8'h80);
    for (int b = 1; b < 4; b++) run(OP_ERASE, 4'(b), 1'b0, 1'b1, 1'b0, 8'h80);
    run(OP_SET_BLOCK, 4'h4, 1'b1, 1'b1, 1'b1, 8'hB0);
    clr(8'hB0);
    run(OP_CLEAR_ALL, 4'h0, 1'b1, 1'b1, 1'b1, 8'hB0);
    clr(8'hB0);
    run(OP_ERASE, 4'h4, 1'b0, 1'b1, 1'b0, 8'h80);
    run(OP_READ_ARRAY, 4'h0, 1'b0, 1'b1, 1'b0, 8'h80);
    give_verdict();
  end
endmodule
`default_nettype wire
